// File: logic/pcim_defines.svh
// Constants of the interrupt and power-management block: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the package and the design modules.
//
// Behaviour
// [R1] Status bits 2 and 3 show live general pin levels after optional inversion.
// [R2] Enables 18 and 19 let pin 0 or 1 assert INTA#, per pin polarity.
// [R3] Bit 20 is a sticky power-down flag, cleared by reading it.
// [R4] Power-down request drives INTA# only while bit 21 is one.
// [R5] Bit 22 shows parallel port interrupt; bit 23 gates it, resets to one.
// [R6] INTA# is a level, held while any enabled source stays active.
// [R7] Both general pins and the parallel port all merge onto INTA#.
// [R8] Interrupt pin field is bus read-only, loaded by EEPROM; 0 none, 1 INTA#.
// [R9] Own power-management registers; only D0, D2 and D3 are supported.
// [R10] PME# stays asserted until PME_Status is cleared, then released.
// [R11] A pin requests power-down when in the opposite of its interrupt state.
// [R12] Power-down filter needs the pins stable for a selectable period.
// [R13] In D2 or D3 the interrupt is off and I/O and memory accesses refused.
// [R14] In D2 and D3 configuration accesses still answer.
// [R15] With pin config bit 6 or 7 set, pin edges set PME_Status if PME enabled.
// [R16] PME_Status is sticky, cleared by writing one; zero leaves it.
// [R17] The global status register answers in both I/O and memory ranges.
// [R18] Pin field: 00 input, 01 inverted input, 10 drive low, 11 drive high.
// [R19] Pin config bits 6 and 7 enable pin 0 or 1 into the power-down filter.
// [R20] With port interrupt enabled, acknowledge rising edge raises status until status read.
// [R21] INTA# driven low open-drain when any enabled source active, only in D0.
// [R22] Filter sets the power-down flag once per stable interval, rearms when pins leave.
`ifndef PCIM_DEFINES_SVH
`define PCIM_DEFINES_SVH

`define PCIM_LCL_MIC 8'h04
`define PCIM_LCL_GIS 8'h10
`define PCIM_CFG_INTR 8'h3C
`define PCIM_CFG_PMCAP 8'h40
`define PCIM_CFG_PMCSR 8'h44

`define PCIM_GIS_PIN0 2
`define PCIM_GIS_PIN1 3
`define PCIM_GIS_EN0 18
`define PCIM_GIS_EN1 19
`define PCIM_GIS_PDF 20
`define PCIM_GIS_PDEN 21
`define PCIM_GIS_PPST 22
`define PCIM_GIS_PPEN 23

`define PCIM_MIC_W 8
`define PCIM_MIC_RST 8'h00
`define PCIM_MIC_PD0 6
`define PCIM_MIC_PD1 7
`define PCIM_PPEN_RST 1'h1
`define PCIM_INTPIN_RST 8'h01
`define PCIM_INTPIN_INTA 8'h01
`define PCIM_PMCAP_VAL 32'h6C01_0001

`define PCIM_PS_D0 2'h0
`define PCIM_PS_D2 2'h2
`define PCIM_PS_D3 2'h3
`define PCIM_PMCSR_PMEEN 8
`define PCIM_PMCSR_PMEST 15

`define PCIM_PDF_BASE 24'h00_0400
`define PCIM_PDF_W 24

`endif

// File: logic/pcim_pkg.sv
// Types shared by the interrupt and power-management block.
// Assumes the defines header is on the include path.
`include "pcim_defines.svh"

package pcim_pkg;

  typedef enum logic [1:0] {
    PCIM_SP_CFG = 2'h0,
    PCIM_SP_IO = 2'h1,
    PCIM_SP_MEM = 2'h2
  } pcim_space_e;

  typedef enum logic [2:0] {
    PCIM_F_IDLE = 3'h1,
    PCIM_F_COUNT = 3'h2,
    PCIM_F_FIRED = 3'h4
  } pcim_fstate_e;

  typedef struct packed {
    logic valid;
    pcim_space_e space;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } pcim_req_s;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [31:0] rdata;
  } pcim_rsp_s;

endpackage

// File: logic/pcim_pd_filter.sv
// Power-down request filter: fires once after its condition holds for a full period.
// Assumes cond comes from synchronised logic on the same clock.
`timescale 1ns/1ps
`include "pcim_defines.svh"

module pcim_pd_filter (
  input wire logic clk, // Clock
  input wire logic srst, // Synchronous reset
  input wire logic cond, // Pins in power-down state
  input wire logic [`PCIM_PDF_W-1:0] period, // Cycles to hold
  output logic fire // One-cycle request
);
  import pcim_pkg::*;

  pcim_fstate_e state_r;
  logic [`PCIM_PDF_W-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Any drop of the condition restarts the wait
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= PCIM_F_IDLE;
    end else if (!cond) begin
      state_r <= PCIM_F_IDLE; // see [R22]
    end else begin
      case (state_r)
        PCIM_F_IDLE: begin
          state_r <= PCIM_F_COUNT;
        end
        PCIM_F_COUNT: begin
          if (cnt_r >= period) begin
            state_r <= PCIM_F_FIRED; // see [R12]
          end
        end
        default: begin
          state_r <= PCIM_F_FIRED; // see [R22]
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_r != PCIM_F_COUNT) begin
      cnt_r <= `PCIM_PDF_W'h1;
    end else begin
      cnt_r <= cnt_r + `PCIM_PDF_W'h1;
    end
  end

  assign fire = cond && state_r == PCIM_F_COUNT && cnt_r >= period;

endmodule // pcim_pd_filter

// File: logic/pcim_top.sv
// Global interrupt status/control and power management of a single-function target.
// Assumes the target core presents decoded register accesses one at a time on REQ.
`timescale 1ns/1ps
`include "pcim_defines.svh"

module pcim_top #(
  parameter logic [`PCIM_PDF_W-1:0] PDF_BASE = `PCIM_PDF_BASE // Shortest filter period
) (
  input wire logic CLK, // Clock, 100 MHz
  input wire logic SRST, // Synchronous reset
  input wire pcim_pkg::pcim_req_s REQ, // Register access request
  output pcim_pkg::pcim_rsp_s RSP, // Register access answer
  input wire logic EE_PIN_WE, // EEPROM load strobe
  input wire logic [7:0] EE_PIN_DATA, // EEPROM interrupt pin value
  input wire logic [1:0] GP_IN, // General pins, pad level
  output logic [1:0] GP_OUT, // General pins, drive value
  output logic [1:0] GP_OE_N, // General pins, low drives
  input wire logic PP_ACK_IN, // Peripheral acknowledge pin
  input wire logic PP_INT_EN, // Port control interrupt enable
  input wire logic PP_STATUS_RD, // Port status register read
  input wire logic [1:0] PD_FILTER_SEL, // Filter period select
  input wire logic INTA_IN, // Interrupt wire level
  output logic INTA_OUT, // Interrupt drive value
  output logic INTA_OE_N, // Interrupt, low drives
  input wire logic PME_IN, // Wake wire level
  output logic PME_OUT, // Wake drive value
  output logic PME_OE_N, // Wake, low drives
  output logic [1:0] POWER_STATE // Current power state
);
  import pcim_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic lcl_hit(input pcim_req_s r, input logic [7:0] a);
    lcl_hit = r.valid && (r.space == PCIM_SP_IO || r.space == PCIM_SP_MEM) && r.addr == a; // see [R17]
  endfunction

  function automatic logic cfg_hit(input pcim_req_s r, input logic [7:0] a);
    cfg_hit = r.valid && r.space == PCIM_SP_CFG && r.addr == a;
  endfunction

  function automatic logic ps_legal(input logic [1:0] ps);
    ps_legal = ps == `PCIM_PS_D0 || ps == `PCIM_PS_D2 || ps == `PCIM_PS_D3; // see [R9]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0] gp_s1_r;
  logic [1:0] gp_s2_r;
  logic [1:0] gp_s3_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_s3_r;
  logic [`PCIM_MIC_W-1:0] mic_r;
  logic en0_r;
  logic en1_r;
  logic pdf_r;
  logic pden_r;
  logic ppst_r;
  logic ppen_r;
  logic [7:0] int_line_r;
  logic [7:0] int_pin_r;
  logic [1:0] ps_r;
  logic pme_en_r;
  logic pme_st_r;
  logic inta_r;
  logic pme_r;
  pcim_rsp_s rsp_r;
  pcim_rsp_s rsp_nxt;
  logic [1:0] inv;
  logic [1:0] gp_int;
  logic [1:0] gp_edge;
  logic [1:0] pd_en;
  logic pd_cond;
  logic pd_fire;
  logic ack_rise;
  logic lcl_ok;
  logic wr_mic;
  logic wr_gis;
  logic rd_gis;
  logic wr_line;
  logic wr_pmcsr;
  logic pme_set;
  logic src_any;
  logic [`PCIM_PDF_W-1:0] period;
  logic [31:0] gis_val;
  logic [31:0] mic_val;
  logic [31:0] intr_val;
  logic [31:0] pmcsr_val;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge CLK) begin
    if (SRST) begin
      gp_s1_r <= 2'h0;
      gp_s2_r <= 2'h0;
      gp_s3_r <= 2'h0;
    end else begin
      gp_s1_r <= GP_IN;
      gp_s2_r <= gp_s1_r;
      gp_s3_r <= gp_s2_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ack_s1_r <= 1'h0;
      ack_s2_r <= 1'h0;
      ack_s3_r <= 1'h0;
    end else begin
      ack_s1_r <= PP_ACK_IN;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sense and drive

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      // Inversion only in input modes; output modes reflect the pad as is
      assign inv[g] = !mic_r[2*g+1] && mic_r[2*g]; // see [R18]
      assign gp_int[g] = gp_s2_r[g] ^ inv[g]; // see [R1]
      assign gp_edge[g] = gp_s2_r[g] ^ gp_s3_r[g];
      assign GP_OUT[g] = mic_r[2*g]; // see [R18]
      assign GP_OE_N[g] = !mic_r[2*g+1]; // see [R18]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  // Local ranges are dead outside D0; config space stays open
  assign lcl_ok = ps_r == `PCIM_PS_D0; // see [R13]
  assign wr_mic = lcl_ok && lcl_hit(REQ, `PCIM_LCL_MIC) && REQ.wr;
  assign wr_gis = lcl_ok && lcl_hit(REQ, `PCIM_LCL_GIS) && REQ.wr;
  assign rd_gis = lcl_ok && lcl_hit(REQ, `PCIM_LCL_GIS) && !REQ.wr;
  assign wr_line = cfg_hit(REQ, `PCIM_CFG_INTR) && REQ.wr; // see [R14]
  assign wr_pmcsr = cfg_hit(REQ, `PCIM_CFG_PMCSR) && REQ.wr; // see [R14]

  ////////////////////////////////////////////////////////////////////////////
  // Pin configuration register

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mic_r <= `PCIM_MIC_RST;
    end else if (wr_mic && REQ.be[0]) begin
      mic_r <= REQ.wdata[`PCIM_MIC_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global enables

  always_ff @(posedge CLK) begin
    if (SRST) begin
      en0_r <= 1'h0;
      en1_r <= 1'h0;
      pden_r <= 1'h0;
      ppen_r <= `PCIM_PPEN_RST; // see [R5]
    end else if (wr_gis && REQ.be[2]) begin
      en0_r <= REQ.wdata[`PCIM_GIS_EN0]; // see [R2]
      en1_r <= REQ.wdata[`PCIM_GIS_EN1]; // see [R2]
      pden_r <= REQ.wdata[`PCIM_GIS_PDEN]; // see [R4]
      ppen_r <= REQ.wdata[`PCIM_GIS_PPEN]; // see [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down request

  generate
    for (g = 0; g < 2; g++) begin : g_pd
      assign pd_en[g] = mic_r[`PCIM_MIC_PD0+g]; // see [R19]
    end
  endgenerate

  // Power-down state is the inverse of the interrupting state
  assign pd_cond = (pd_en != 2'h0) && ((~gp_int & pd_en) == pd_en); // see [R11]
  assign period = PDF_BASE << {PD_FILTER_SEL, 1'h0}; // see [R12]

  pcim_pd_filter u_filter (
    .clk(CLK),
    .srst(SRST),
    .cond(pd_cond),
    .period(period),
    .fire(pd_fire)
  );

  // Set wins over the read that clears
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pdf_r <= 1'h0;
    end else if (pd_fire) begin
      pdf_r <= 1'h1; // see [R3] [R22]
    end else if (rd_gis) begin
      pdf_r <= 1'h0; // see [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel port interrupt status

  assign ack_rise = ack_s2_r && !ack_s3_r;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ppst_r <= 1'h0;
    end else if (ack_rise && PP_INT_EN) begin
      ppst_r <= 1'h1; // see [R20]
    end else if (PP_STATUS_RD) begin
      ppst_r <= 1'h0; // see [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration: interrupt line and pin

  always_ff @(posedge CLK) begin
    if (SRST) begin
      int_line_r <= 8'h00;
    end else if (wr_line && REQ.be[0]) begin
      int_line_r <= REQ.wdata[7:0];
    end
  end

  // Bus writes never reach the pin field
  always_ff @(posedge CLK) begin
    if (SRST) begin
      int_pin_r <= `PCIM_INTPIN_RST;
    end else if (EE_PIN_WE) begin
      int_pin_r <= EE_PIN_DATA; // see [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power management control/status

  // Unsupported states are ignored, so D1 can never be entered
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ps_r <= `PCIM_PS_D0;
    end else if (wr_pmcsr && REQ.be[0] && ps_legal(REQ.wdata[1:0])) begin
      ps_r <= REQ.wdata[1:0]; // see [R9]
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pme_en_r <= 1'h0;
    end else if (wr_pmcsr && REQ.be[1]) begin
      pme_en_r <= REQ.wdata[`PCIM_PMCSR_PMEEN];
    end
  end

  assign pme_set = pme_en_r && ((gp_edge[0] && mic_r[`PCIM_MIC_PD0]) ||
                                (gp_edge[1] && mic_r[`PCIM_MIC_PD1])); // see [R15]

  // Edge in the clearing cycle keeps the flag
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pme_st_r <= 1'h0;
    end else if (pme_set) begin
      pme_st_r <= 1'h1; // see [R15]
    end else if (wr_pmcsr && REQ.be[1] && REQ.wdata[`PCIM_PMCSR_PMEST]) begin
      pme_st_r <= 1'h0; // see [R16]
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pme_r <= 1'h0;
    end else begin
      pme_r <= pme_st_r && pme_en_r; // see [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt merge

  assign src_any = (gp_int[0] && en0_r) || (gp_int[1] && en1_r) || // see [R2] [R7]
                   (pdf_r && pden_r) || // see [R4]
                   (ppst_r && ppen_r); // see [R5] [R7]

  // A level, never a pulse, so a shared line stays low while work remains
  always_ff @(posedge CLK) begin
    if (SRST) begin
      inta_r <= 1'h0;
    end else begin
      inta_r <= src_any && ps_r == `PCIM_PS_D0 && int_pin_r == `PCIM_INTPIN_INTA; // see [R6] [R13] [R21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    gis_val = 32'h0000_0000;
    gis_val[`PCIM_GIS_PIN0] = gp_int[0]; // see [R1]
    gis_val[`PCIM_GIS_PIN1] = gp_int[1]; // see [R1]
    gis_val[`PCIM_GIS_EN0] = en0_r;
    gis_val[`PCIM_GIS_EN1] = en1_r;
    gis_val[`PCIM_GIS_PDF] = pdf_r;
    gis_val[`PCIM_GIS_PDEN] = pden_r;
    gis_val[`PCIM_GIS_PPST] = ppst_r; // see [R5]
    gis_val[`PCIM_GIS_PPEN] = ppen_r;
  end

  assign mic_val = {24'h00_0000, mic_r};
  assign intr_val = {16'h0000, int_pin_r, int_line_r};
  assign pmcsr_val = {16'h0000, pme_st_r, 6'h00, pme_en_r, 6'h00, ps_r};

  always_comb begin
    rsp_nxt = '0;
    rsp_nxt.valid = REQ.valid;
    if (REQ.valid && REQ.space != PCIM_SP_CFG && !lcl_ok) begin
      rsp_nxt.refused = 1'h1; // see [R13]
    end else if (REQ.wr) begin
      rsp_nxt.rdata = 32'h0000_0000;
    end else if (lcl_hit(REQ, `PCIM_LCL_GIS)) begin
      rsp_nxt.rdata = gis_val; // see [R17]
    end else if (lcl_hit(REQ, `PCIM_LCL_MIC)) begin
      rsp_nxt.rdata = mic_val;
    end else if (cfg_hit(REQ, `PCIM_CFG_INTR)) begin
      rsp_nxt.rdata = intr_val; // see [R8] [R14]
    end else if (cfg_hit(REQ, `PCIM_CFG_PMCAP)) begin
      rsp_nxt.rdata = `PCIM_PMCAP_VAL; // see [R9]
    end else if (cfg_hit(REQ, `PCIM_CFG_PMCSR)) begin
      rsp_nxt.rdata = pmcsr_val; // see [R14]
    end else begin
      rsp_nxt.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Wire levels are not needed: both lines are only ever pulled low here
  assign RSP = rsp_r;
  assign INTA_OUT = 1'h0;
  assign INTA_OE_N = !inta_r; // see [R21]
  assign PME_OUT = 1'h0;
  assign PME_OE_N = !pme_r; // see [R10]
  assign POWER_STATE = ps_r;

endmodule // pcim_top

// File: verif/pcim_top_asserts.sv
// Concurrent checks on the ports of the interrupt and power-management block.
// Assumes a bind onto pcim_top; one clock, SRST synchronous active high.
`timescale 1ns/1ps
`include "pcim_defines.svh"

module pcim_asserts (
  input wire logic CLK, // Clock
  input wire logic SRST, // Synchronous reset
  input wire pcim_pkg::pcim_req_s REQ, // Access request
  input wire pcim_pkg::pcim_rsp_s RSP, // Access answer
  input wire logic [1:0] GP_OUT, // Pin drive value
  input wire logic [1:0] GP_OE_N, // Pin drive enable
  input wire logic INTA_OUT, // Interrupt drive value
  input wire logic INTA_OE_N, // Interrupt drive enable
  input wire logic PME_OUT, // Wake drive value
  input wire logic PME_OE_N, // Wake drive enable
  input wire logic [1:0] POWER_STATE // Power state
);
  import pcim_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [7:0] wlo_r;
  logic pm_wr;
  logic mic_wr;

  // Low write byte kept so a check one edge later can compare against it
  always_ff @(posedge CLK) begin
    wlo_r <= REQ.wdata[7:0];
  end
  assign pm_wr = REQ.valid && REQ.wr && REQ.space == PCIM_SP_CFG && REQ.addr == `PCIM_CFG_PMCSR;
  assign mic_wr = REQ.valid && REQ.wr && REQ.space != PCIM_SP_CFG && REQ.addr == `PCIM_LCL_MIC && REQ.be[0]
    && POWER_STATE == `PCIM_PS_D0;

  rsp_timing_a: assert property (RSP.valid == $past(REQ.valid))
    else $error("answer not one edge after request");
  refuse_lowpwr_a: assert property (REQ.valid && REQ.space != PCIM_SP_CFG && POWER_STATE != `PCIM_PS_D0
    |=> RSP.refused && RSP.rdata == 32'h0) else $error("local access answered in low power");
  cfg_answer_a: assert property (REQ.valid && REQ.space == PCIM_SP_CFG |=> !RSP.refused)
    else $error("config access refused");
  inta_gate_a: assert property ($past(POWER_STATE) != `PCIM_PS_D0 |-> INTA_OE_N)
    else $error("interrupt driven outside D0");
  open_drain_a: assert property (INTA_OUT == 1'b0 && PME_OUT == 1'b0)
    else $error("shared line driven high");
  pin_drive_a: assert property (mic_wr |=> GP_OE_N == ~{wlo_r[3], wlo_r[1]} && GP_OUT == {wlo_r[2], wlo_r[0]})
    else $error("pin mode not applied");
  state_write_a: assert property (pm_wr && REQ.be[0] && REQ.wdata[1:0] != 2'h1 |=> POWER_STATE == wlo_r[1:0])
    else $error("power state not taken");
  state_keep_a: assert property (pm_wr && REQ.be[0] && REQ.wdata[1:0] == 2'h1 |=> $stable(POWER_STATE))
    else $error("unsupported power state taken");
  pme_release_a: assert property (pm_wr && REQ.be[1] && !REQ.wdata[8] |=> ##1 PME_OE_N)
    else $error("wake line held with wake disabled");
endmodule // pcim_asserts

// File: verif/pcim_sys_model.sv
// Board and system side: general pin pads and the pulled-up shared wires.
// Assumes the bench sets the outside device level on each general pin.
`timescale 1ns/1ps

module pcim_sys_model (
  input wire logic [1:0] gp_out, // Device pin drive value
  input wire logic [1:0] gp_oe_n, // Device pin enable, low drives
  input wire logic inta_out, // Device interrupt value
  input wire logic inta_oe_n, // Device interrupt enable
  input wire logic pme_out, // Device wake value
  input wire logic pme_oe_n, // Device wake enable
  input wire logic [1:0] ext_gp, // Outside device level
  output logic [1:0] gp_in, // Pad levels
  output logic inta_in, // Interrupt wire
  output logic pme_in // Wake wire
);
  // Outside device yields a pin whenever the block drives it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      gp_in[i] = gp_oe_n[i] ? ext_gp[i] : gp_out[i];
    end
    inta_in = inta_oe_n ? 1'b1 : inta_out;
    pme_in = pme_oe_n ? 1'b1 : pme_out;
  end
endmodule // pcim_sys_model

// File: verif/pcim_top_bench.sv
// Self-checking bench for the interrupt and power-management block.
// Assumes the package and design files are compiled before this one.
`timescale 1ns/1ps
`include "pcim_defines.svh"

module pcim_top_bench;
  import pcim_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  pcim_req_s req = '0;
  pcim_rsp_s rsp;
  logic ee_we = 1'b0;
  logic [7:0] ee_data = 8'h00;
  logic [1:0] gp_in, gp_out, gp_oe_n, pstate;
  logic [1:0] ext_gp = 2'h0;
  logic [1:0] pd_sel = 2'h0;
  logic pp_ack = 1'b0, pp_en = 1'b0, pp_rd = 1'b0;
  logic inta_in, inta_out, inta_oe_n, pme_in, pme_out, pme_oe_n, last_ref;
  int n_mismatch = 0, tests_run = 0;

  always #5 clk = ~clk;

  // Short filter base keeps the power-down waits small
  pcim_top #(.PDF_BASE(24'h00_0004)) pcim_top_i (.CLK(clk), .SRST(srst), .REQ(req), .RSP(rsp),
    .EE_PIN_WE(ee_we), .EE_PIN_DATA(ee_data), .GP_IN(gp_in), .GP_OUT(gp_out), .GP_OE_N(gp_oe_n),
    .PP_ACK_IN(pp_ack), .PP_INT_EN(pp_en), .PP_STATUS_RD(pp_rd), .PD_FILTER_SEL(pd_sel),
    .INTA_IN(inta_in), .INTA_OUT(inta_out), .INTA_OE_N(inta_oe_n), .PME_IN(pme_in),
    .PME_OUT(pme_out), .PME_OE_N(pme_oe_n), .POWER_STATE(pstate));
  pcim_sys_model pcim_sys_model_i (.gp_out(gp_out), .gp_oe_n(gp_oe_n), .inta_out(inta_out),
    .inta_oe_n(inta_oe_n), .pme_out(pme_out), .pme_oe_n(pme_oe_n), .ext_gp(ext_gp), .gp_in(gp_in),
    .inta_in(inta_in), .pme_in(pme_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Request stands over one rising edge; answer is read at the next falling edge
  task automatic acc(input pcim_space_e sp, input logic wr, input logic [7:0] a, input logic [31:0] wd,
    input logic [3:0] be, output logic [31:0] rd);
    @(negedge clk);
    req = '{1'b1, sp, wr, a, wd, be};
    @(negedge clk);
    rd = rsp.rdata;
    last_ref = rsp.refused;
    chk1(rsp.valid, 1'b1);
    req.valid = 1'b0;
  endtask
  task automatic rdc(input pcim_space_e sp, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    acc(sp, 1'b0, a, 32'h0, 4'hF, d);
    chk(d & m, e);
  endtask
  task automatic wrc(input pcim_space_e sp, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] x;
    acc(sp, 1'b1, a, d, be, x);
  endtask
  task automatic ee_load(input logic [7:0] v);
    ee_data = v;
    ee_we = 1'b1;
    cyc(1);
    ee_we = 1'b0;
    cyc(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    cyc(2);
    chk({28'h0, gp_oe_n, gp_out}, 32'hC);
    chk({29'h0, inta_oe_n, pme_oe_n, rsp.valid}, 32'h6);
    chk({30'h0, pstate}, 32'h0);
    srst = 1'b0;
    cyc(4);
    rdc(PCIM_SP_IO, 8'h10, 32'hFFEF_FFFF, 32'h0080_0000);
    rdc(PCIM_SP_MEM, 8'h10, 32'hFFEF_FFFF, 32'h0080_0000);
    rdc(PCIM_SP_IO, 8'h20, 32'hFFFF_FFFF, 32'h0);
    rdc(PCIM_SP_CFG, 8'h3C, 32'hFFFF_FFFF, 32'h0000_0100);
    wrc(PCIM_SP_CFG, 8'h3C, 32'hFFFF_FFFF, 4'hF);
    rdc(PCIM_SP_CFG, 8'h3C, 32'hFFFF_FFFF, 32'h0000_01FF);
    ee_load(8'h00);
    rdc(PCIM_SP_CFG, 8'h3C, 32'hFFFF_FF00, 32'h0);
    ee_load(8'h01);
    // Pin modes: inverting input, then both pins as outputs
    wrc(PCIM_SP_IO, 8'h04, 32'h1, 4'h1);
    cyc(4);
    rdc(PCIM_SP_IO, 8'h10, 32'hC, 32'h4);
    wrc(PCIM_SP_MEM, 8'h04, 32'h0E, 4'h1);
    cyc(4);
    chk({28'h0, gp_oe_n, gp_out}, 32'h2);
    rdc(PCIM_SP_IO, 8'h10, 32'hC, 32'h8);
    wrc(PCIM_SP_IO, 8'h04, 32'h0, 4'h1);
    for (int i = 0; i < 2; i++) begin
      wrc(PCIM_SP_IO, 8'h10, 32'h0080_0000 | (32'h0004_0000 << i), 4'h4);
      ext_gp = 2'h1 << i;
      cyc(5);
      chk1(inta_in, 1'b0);
      cyc(20);
      chk1(inta_in, 1'b0);
      ext_gp = 2'h0;
      cyc(5);
      chk1(inta_in, 1'b1);
    end
    wrc(PCIM_SP_IO, 8'h04, 32'h1, 4'h1);
    cyc(5);
    chk1(inta_in, 1'b1);
    wrc(PCIM_SP_IO, 8'h10, 32'h0084_0000, 4'h4);
    cyc(2);
    chk1(inta_in, 1'b0);
    ext_gp = 2'h1;
    cyc(5);
    chk1(inta_in, 1'b1);
    wrc(PCIM_SP_IO, 8'h10, 32'h0080_0000, 4'h4);
    // Parallel port: acknowledge edges with gate on, gate off, enable off
    for (int k = 0; k < 3; k++) begin
      pp_en = (k != 2);
      if (k == 1) wrc(PCIM_SP_IO, 8'h10, 32'h0, 4'h4);
      pp_ack = 1'b1;
      cyc(5);
      pp_ack = 1'b0;
      rdc(PCIM_SP_IO, 8'h10, 32'h0040_0000, (k != 2) ? 32'h0040_0000 : 32'h0);
      chk1(inta_in, k != 0);
      pp_rd = 1'b1;
      cyc(1);
      pp_rd = 1'b0;
      cyc(2);
      rdc(PCIM_SP_IO, 8'h10, 32'h0040_0000, 32'h0);
      chk1(inta_in, 1'b1);
    end
    wrc(PCIM_SP_IO, 8'h10, 32'h0080_0000, 4'h4);
    // Power-down filter on pin 0 at two period selections
    ext_gp = 2'h1;
    wrc(PCIM_SP_IO, 8'h04, 32'h40, 4'h1);
    for (int s = 0; s < 2; s++) begin
      pd_sel = s[1:0];
      ext_gp = 2'h1;
      cyc(4);
      rdc(PCIM_SP_IO, 8'h10, 32'h0, 32'h0);
      ext_gp = 2'h0;
      rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0);
      // Read lands two edges before the selected period runs out
      cyc((4 << (2 * s)) - 3);
      rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0);
      cyc(4 << (2 * s));
      chk1(inta_in, 1'b1);
      rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0010_0000);
      rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0);
    end
    cyc(60);
    rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0);
    ext_gp = 2'h1;
    cyc(4);
    ext_gp = 2'h0;
    cyc(50);
    wrc(PCIM_SP_IO, 8'h10, 32'h00A0_0000, 4'h4);
    cyc(2);
    chk1(inta_in, 1'b0);
    rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0010_0000);
    cyc(3);
    chk1(inta_in, 1'b1);
    wrc(PCIM_SP_IO, 8'h10, 32'h0080_0000, 4'h4);
    // Pin 1 joins the filter: no request while it is high
    ext_gp = 2'h3;
    wrc(PCIM_SP_IO, 8'h04, 32'hC0, 4'h1);
    ext_gp = 2'h2;
    cyc(30);
    rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0);
    ext_gp = 2'h0;
    cyc(30);
    rdc(PCIM_SP_IO, 8'h10, 32'h0010_0000, 32'h0010_0000);
    // Wake events on pin 0 edges, then a pin 1 edge
    ext_gp = 2'h1;
    cyc(5);
    rdc(PCIM_SP_CFG, 8'h44, 32'h8000, 32'h0);
    wrc(PCIM_SP_CFG, 8'h44, 32'h0100, 4'h2);
    cyc(2);
    chk1(pme_in, 1'b1);
    ext_gp = 2'h0;
    cyc(5);
    chk1(pme_in, 1'b0);
    rdc(PCIM_SP_CFG, 8'h44, 32'h8100, 32'h8100);
    wrc(PCIM_SP_CFG, 8'h44, 32'h0100, 4'h2);
    cyc(3);
    chk1(pme_in, 1'b0);
    wrc(PCIM_SP_CFG, 8'h44, 32'h8100, 4'h2);
    cyc(3);
    chk1(pme_in, 1'b1);
    rdc(PCIM_SP_CFG, 8'h44, 32'h8100, 32'h0100);
    ext_gp = 2'h2;
    cyc(5);
    chk1(pme_in, 1'b0);
    wrc(PCIM_SP_CFG, 8'h44, 32'h8000, 4'h2);
    cyc(3);
    chk1(pme_in, 1'b1);
    // Low power states with a pending pin interrupt
    ext_gp = 2'h3;
    wrc(PCIM_SP_IO, 8'h10, 32'h0084_0000, 4'h4);
    cyc(4);
    chk1(inta_in, 1'b0);
    wrc(PCIM_SP_CFG, 8'h44, 32'h3, 4'h1);
    cyc(3);
    chk1(inta_in, 1'b1);
    rdc(PCIM_SP_IO, 8'h10, 32'hFFFF_FFFF, 32'h0);
    chk1(last_ref, 1'b1);
    wrc(PCIM_SP_MEM, 8'h04, 32'h0E, 4'h1);
    cyc(2);
    chk({30'h0, gp_oe_n}, 32'h3);
    rdc(PCIM_SP_CFG, 8'h44, 32'h3, 32'h3);
    rdc(PCIM_SP_CFG, 8'h40, 32'hFFFF_FFFF, `PCIM_PMCAP_VAL);
    wrc(PCIM_SP_CFG, 8'h44, 32'h1, 4'h1);
    rdc(PCIM_SP_CFG, 8'h44, 32'h3, 32'h3);
    wrc(PCIM_SP_CFG, 8'h44, 32'h2, 4'h1);
    rdc(PCIM_SP_CFG, 8'h44, 32'h3, 32'h2);
    chk1(inta_in, 1'b1);
    wrc(PCIM_SP_CFG, 8'h44, 32'h0, 4'h1);
    cyc(3);
    chk1(inta_in, 1'b0);
    rdc(PCIM_SP_MEM, 8'h10, 32'h0084_0000, 32'h0084_0000);
    chk1(last_ref, 1'b0);
    ee_load(8'h00);
    cyc(3);
    chk1(inta_in, 1'b1);
    ee_load(8'h01);
    cyc(3);
    chk1(inta_in, 1'b0);
    complete_run();
  end
endmodule // pcim_top_bench

bind pcim_top pcim_asserts pcim_asserts_i (.CLK(CLK), .SRST(SRST), .REQ(REQ), .RSP(RSP), .GP_OUT(GP_OUT),
  .GP_OE_N(GP_OE_N), .INTA_OUT(INTA_OUT), .INTA_OE_N(INTA_OE_N), .PME_OUT(PME_OUT), .PME_OE_N(PME_OE_N),
  .POWER_STATE(POWER_STATE));
